// ===== bench/flash_array_side_model.sv
// processor side of the flash array: issues array accesses and
// tallies the command and key strobes handed back by the block
`timescale 1ns/1ns
module flash_array_side_model (
    // clock
    input wire sys_clk,
    // strobes from the block
    input wire commandWriteStart,
    input wire backdoorKeyWrite,
    input wire arrayReadGrant,
    // accesses towards the block
    output reg arrayWrite,
    output reg arrayRead
);
    integer cmdSeen = 0;
    integer keySeen = 0;
    integer grantSeen = 0;
    initial begin
        arrayWrite = 1'b0;
        arrayRead = 1'b0;
    end
    // tally strobes; unknowns never count
    always @(posedge sys_clk) begin
        if (commandWriteStart === 1'b1) cmdSeen <= cmdSeen + 1;
        if (backdoorKeyWrite === 1'b1) keySeen <= keySeen + 1;
        if (arrayReadGrant === 1'b1) grantSeen <= grantSeen + 1;
    end
    // one-cycle write, then a two-cycle read
    task accessArray;
        begin
            @(posedge sys_clk);
            arrayWrite <= 1'b1;
            @(posedge sys_clk);
            arrayWrite <= 1'b0;
            arrayRead <= 1'b1;
            repeat (2) @(posedge sys_clk);
            arrayRead <= 1'b0;
        end
    endtask
endmodule

// ===== bench/flash_timing_and_security_cfg_assertions.sv
// concurrent checks on the flash timing and security front end
// assumes single clock domain and srst as its synchronous reset
`timescale 1ns/1ns
`include "flash_timing_and_security_cfg_map.vh"
module flash_timing_and_security_cfg_assertions (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // register bus
    input wire awvalid,
    input wire awready,
    input wire [`FTS_ADDR_W-1:0] awaddr,
    input wire wvalid,
    input wire wready,
    input wire [3:0] wstrb,
    input wire bvalid,
    input wire [1:0] bresp,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    // array side and state
    input wire arrayWrite,
    input wire arrayRead,
    input wire backdoorUnlock,
    input wire commandWriteStart,
    input wire backdoorKeyWrite,
    input wire arrayReadGrant,
    input wire backdoorKeyEnable,
    input wire deviceSecured,
    input wire keyWriteAccess
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // both halves in one edge, as the bench always offers them
    sequence s_wrTake;
        awvalid && awready && wvalid && wready;
    endsequence
    property p_slverr;
        s_wrTake ##0 (wstrb != 4'h1 && awaddr < 8'h40) |=> ##1 bvalid && bresp == 2'h2;
    endproperty
    property p_decerr;
        s_wrTake ##0 (wstrb == 4'h1 && awaddr >= 8'h40) |=> ##1 bvalid && bresp == 2'h3;
    endproperty
    property p_rd;
        arvalid && arready |=> rvalid;
    endproperty
    property p_cmd;
        arrayWrite && !keyWriteAccess |=> commandWriteStart && !backdoorKeyWrite;
    endproperty
    property p_key;
        arrayWrite && keyWriteAccess |=> backdoorKeyWrite && !commandWriteStart;
    endproperty
    property p_grant;
        arrayReadGrant == arrayRead;
    endproperty
    // access bit frozen while the key feature is off
    property p_kacc;
        !backdoorKeyEnable |=> $stable(keyWriteAccess);
    endproperty
    property p_unlockOpen;
        backdoorUnlock |=> !deviceSecured [*8];
    endproperty
    a_slverr: assert property (p_slverr) else $error("wide write not refused");
    a_decerr: assert property (p_decerr) else $error("out of window not decerr");
    a_rd: assert property (p_rd) else $error("read answer late");
    a_cmd: assert property (p_cmd) else $error("command start missing");
    a_key: assert property (p_key) else $error("key write missing");
    a_grant: assert property (p_grant) else $error("array read gated");
    a_kacc: assert property (p_kacc) else $error("access bit moved");
    a_unlockOpen: assert property (p_unlockOpen) else $error("still secured after unlock");
endmodule
bind flash_timing_and_security_cfg flash_timing_and_security_cfg_assertions u_chk (
    .sys_clk, .srst, .awvalid, .awready, .awaddr, .wvalid, .wready, .wstrb, .bvalid,
    .bresp, .arvalid, .arready, .rvalid, .arrayWrite, .arrayRead, .backdoorUnlock,
    .commandWriteStart, .backdoorKeyWrite, .arrayReadGrant, .backdoorKeyEnable,
    .deviceSecured, .keyWriteAccess
);

// ===== bench/flash_timing_and_security_cfg_tb_top.sv
// self-checking bench for the flash timing and security front end
// assumes the bound checker and the array-side model beside it
`timescale 1ns/1ns
`include "flash_timing_and_security_cfg_map.vh"
module flash_timing_and_security_cfg_tb_top;
    // ----------------------------------------------------------------
    // stimulus and wiring
    // ----------------------------------------------------------------
    reg sys_clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg arvalid = 1'b0, rready = 1'b0, backdoorUnlock = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00, nvOptionsByte = 8'h00;
    reg [31:0] wdata = 32'h00000000;
    reg [3:0] wstrb = 4'h0;
    wire awready, wready, bvalid, arready, rvalid, commandWriteStart, backdoorKeyWrite;
    wire arrayReadGrant, timingTick, backdoorKeyEnable, deviceSecured, keyWriteAccess;
    wire arrayWrite, arrayRead;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer miscompares = 0, cmpCount = 0, k;
    localparam [7:0] DIV = `FTS_TIMING_DIV_OFS, OPT = `FTS_SECURITY_OPTIONS_OFS;
    localparam [7:0] KEY = `FTS_KEY_CFG_OFS;
    always #2 sys_clk = ~sys_clk;
    flash_timing_and_security_cfg u_dut (.sys_clk, .srst, .awvalid, .awready, .awaddr,
        .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
        .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .nvOptionsByte,
        .backdoorUnlock, .arrayWrite, .arrayRead, .commandWriteStart, .backdoorKeyWrite,
        .arrayReadGrant, .timingTick, .backdoorKeyEnable, .deviceSecured, .keyWriteAccess);
    flash_array_side_model u_far (.sys_clk, .commandWriteStart, .backdoorKeyWrite,
        .arrayReadGrant, .arrayWrite, .arrayRead);
    task give_verdict;
        begin
            $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
            if (miscompares == 0 && cmpCount > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmpCount = cmpCount + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // option byte only changes while reset is held
    task doReset(input [7:0] nv);
        begin
            nvOptionsByte <= nv;
            srst <= 1'b1;
            repeat (16) @(posedge sys_clk);
            srst <= 1'b0;
        end
    endtask
    // address and data offered together, each released when taken
    task wr(input [7:0] a, input [7:0] d, input [3:0] s, input [1:0] er);
        integer n;
        begin
            @(posedge sys_clk);
            {awvalid, wvalid, bready} <= 3'h7;
            awaddr <= a;
            wdata <= {24'h000000, d};
            wstrb <= s;
            n = 0;
            do begin
                @(posedge sys_clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                n = n + 1;
            end while (bvalid !== 1'b1 && n < 50);
            bready <= 1'b0;
            chk({31'h0, bvalid}, 32'h1);
            chk({30'h0, bresp}, {30'h0, er});
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
        integer n;
        begin
            @(posedge sys_clk);
            {arvalid, rready} <= 2'h3;
            araddr <= a;
            n = 0;
            do begin
                @(posedge sys_clk);
                if (arready) arvalid <= 1'b0;
                n = n + 1;
            end while (rvalid !== 1'b1 && n < 50);
            rready <= 1'b0;
            chk({31'h0, rvalid}, 32'h1);
            chk(rdata, exp);
            chk({30'h0, rresp}, {30'h0, er});
        end
    endtask
    // cycles between two timing ticks
    task tickGap(input integer exp);
        integer n;
        begin
            n = 0;
            while (timingTick !== 1'b1 && n < 1100) begin
                @(posedge sys_clk);
                n = n + 1;
            end
            n = 0;
            do begin
                @(posedge sys_clk);
                n = n + 1;
            end while (timingTick !== 1'b1 && n < 1100);
            chk(n, exp);
        end
    endtask
    task arrayAccess(input integer expCmd, input integer expKey);
        integer c, kk, g;
        begin
            c = u_far.cmdSeen;
            kk = u_far.keySeen;
            g = u_far.grantSeen;
            u_far.accessArray;
            repeat (2) @(posedge sys_clk);
            chk(u_far.cmdSeen - c, expCmd);
            chk(u_far.keySeen - kk, expKey);
            chk(u_far.grantSeen - g, 2);
        end
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task scenBus;
        begin
            doReset(8'h82);
            rd(DIV, 32'h0, `FTS_RESP_OKAY);
            rd(OPT, 32'h82, `FTS_RESP_OKAY);
            wr(OPT, 8'h00, 4'h1, `FTS_RESP_OKAY);
            rd(OPT, 32'h82, `FTS_RESP_OKAY);
            rd(8'h3c, 32'h0, `FTS_RESP_OKAY);
            wr(8'h40, 8'h81, 4'h1, `FTS_RESP_DECERR);
            wr(DIV, 8'h81, 4'hf, `FTS_RESP_SLVERR);
            rd(DIV, 32'h0, `FTS_RESP_OKAY);
        end
    endtask
    // open write, max ratio, closing write, ratio of two, then locked
    task scenDivider;
        begin
            wr(DIV, 8'hff, 4'h1, `FTS_RESP_OKAY);
            rd(DIV, 32'hff, `FTS_RESP_OKAY);
            tickGap(512);
            wr(DIV, 8'h01, 4'h1, `FTS_RESP_OKAY);
            rd(DIV, 32'h81, `FTS_RESP_OKAY);
            tickGap(2);
            wr(DIV, 8'h3f, 4'h1, `FTS_RESP_OKAY);
            rd(DIV, 32'h81, `FTS_RESP_OKAY);
        end
    endtask
    task scenKey;
        begin
            wr(KEY, 8'hff, 4'h1, `FTS_RESP_OKAY);
            rd(KEY, 32'h20, `FTS_RESP_OKAY);
            chk({31'h0, keyWriteAccess}, 32'h1);
            arrayAccess(0, 1);
            wr(KEY, 8'h00, 4'h1, `FTS_RESP_OKAY);
            arrayAccess(1, 0);
            chk({31'h0, deviceSecured}, 32'h1);
            @(posedge sys_clk);
            backdoorUnlock <= 1'b1;
            @(posedge sys_clk);
            backdoorUnlock <= 1'b0;
            @(posedge sys_clk);
            chk({31'h0, deviceSecured}, 32'h0);
            rd(OPT, 32'h83, `FTS_RESP_OKAY);
        end
    endtask
    // key feature off: first write with loaded bit clear locks
    task scenLock;
        begin
            doReset(8'h42);
            wr(DIV, 8'h05, 4'h1, `FTS_RESP_OKAY);
            wr(DIV, 8'hc0, 4'h1, `FTS_RESP_OKAY);
            rd(DIV, 32'h85, `FTS_RESP_OKAY);
            tickGap(6);
            wr(KEY, 8'h20, 4'h1, `FTS_RESP_OKAY);
            rd(KEY, 32'h0, `FTS_RESP_OKAY);
            chk({31'h0, keyWriteAccess}, 32'h0);
            arrayAccess(1, 0);
        end
    endtask
    task scenCodes;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                doReset({k[1:0], 4'h0, k[1:0]});
                @(posedge sys_clk);
                chk({31'h0, backdoorKeyEnable}, {31'h0, k == 2});
                chk({31'h0, deviceSecured}, {31'h0, k == 2});
            end
        end
    endtask
    // watchdog well beyond the thousand or so cycles the run needs
    initial begin
        #40000;
        miscompares = miscompares + 1;
        give_verdict;
    end
    initial begin
        scenBus;
        scenDivider;
        scenKey;
        scenLock;
        scenCodes;
        give_verdict;
    end
endmodule

// ===== core/flash_timing_and_security_cfg.v
// flash timing divider, security options and key access gate, with an
// axi4-lite register slave; assumes one 250 mhz clock, a synchronous
// reset, and an option byte that is stable while reset is held.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "flash_timing_and_security_cfg_map.vh"

module flash_timing_and_security_cfg (
    // clock and reset
    input wire sys_clk,
    input wire srst,
    // axi4-lite write address
    input wire awvalid,
    output wire awready,
    input wire [`FTS_ADDR_W-1:0] awaddr,
    input wire [2:0] awprot,
    // axi4-lite write data
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // axi4-lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // axi4-lite read address
    input wire arvalid,
    output wire arready,
    input wire [`FTS_ADDR_W-1:0] araddr,
    input wire [2:0] arprot,
    // axi4-lite read data
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // nonvolatile option byte and unlock event from the key comparator
    input wire [7:0] nvOptionsByte,
    input wire backdoorUnlock,
    // flash array access strobes from the processor side
    input wire arrayWrite,
    input wire arrayRead,
    // towards the command sequencer and key comparator
    output reg commandWriteStart,
    output reg backdoorKeyWrite,
    output wire arrayReadGrant,
    // state seen by the rest of the flash controller
    output reg timingTick,
    output wire backdoorKeyEnable,
    output wire deviceSecured,
    output wire keyWriteAccess
);

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------

    // response for an access: outside the 16-word window is a decode error
    function [1:0] accessResp;
        input [`FTS_ADDR_W-1:0] addr;
        input isWrite;
        input [3:0] strb;
        begin
            if (addr[`FTS_ADDR_W-1:`FTS_TOP_LSB] != 2'h0) begin
                accessResp = `FTS_RESP_DECERR;
            end else if (isWrite && strb != `FTS_BYTE_STRB) begin
                accessResp = `FTS_RESP_SLVERR;
            end else begin
                accessResp = `FTS_RESP_OKAY;
            end
        end
    endfunction

    // word-aligned register offset of an address
    function [`FTS_ADDR_W-1:0] wordOfs;
        input [`FTS_ADDR_W-1:0] addr;
        begin
            wordOfs = {addr[`FTS_ADDR_W-1:`FTS_IDX_LSB], 2'h0};
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg [7:0] optionsR;
    reg unlockedR;
    reg divLoadedR;
    reg divLockedR;
    reg prescaleR;
    reg [5:0] divValueR;
    reg keyAccessR;
    reg [2:0] preCntR;
    reg [5:0] divCntR;
    reg awHeldR;
    reg wHeldR;
    reg [`FTS_ADDR_W-1:0] awAddrR;
    reg [7:0] wByteR;
    reg [3:0] wStrbR;
    reg [7:0] readByte;
    reg [1:0] securityField;
    wire doWrite;
    wire [1:0] wrResp;
    wire wrOk;
    wire [`FTS_ADDR_W-1:0] wrOfs;
    wire divWrite;
    wire preTick;

    // ----------------------------------------------------------------
    // option decode
    // ----------------------------------------------------------------

    // key access is only meaningful for the single enabled code
    assign backdoorKeyEnable =
        (optionsR[`FTS_KEY_ENABLE_MSB:`FTS_KEY_ENABLE_LSB] == `FTS_KEY_ENABLE_ON);

    // unlock overrides whatever the option byte asked for
    always @* begin
        if (unlockedR) begin
            securityField = `FTS_SECURITY_FORCED_OPEN;
        end else begin
            securityField = optionsR[`FTS_SECURITY_MSB:`FTS_SECURITY_LSB];
        end
    end

    assign deviceSecured = (securityField == `FTS_SECURITY_SECURED);
    assign keyWriteAccess = keyAccessR;

    // ----------------------------------------------------------------
    // write channel handshake
    // ----------------------------------------------------------------

    // each half is taken once and held, so address and data may come in
    // either order; nothing new is taken while a response waits
    assign awready = !awHeldR && !bvalid;
    assign wready = !wHeldR && !bvalid;
    assign doWrite = awHeldR && wHeldR && !bvalid;
    assign wrResp = accessResp(awAddrR, 1'b1, wStrbR);
    assign wrOk = doWrite && (wrResp == `FTS_RESP_OKAY);
    assign wrOfs = wordOfs(awAddrR);
    assign divWrite = wrOk && (wrOfs == `FTS_TIMING_DIV_OFS);

    // capture address and data halves
    always @(posedge sys_clk) begin
        if (srst) begin
            awHeldR <= 1'b0;
            wHeldR <= 1'b0;
            awAddrR <= `FTS_BYTE_ZERO;
            wByteR <= `FTS_BYTE_ZERO;
            wStrbR <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                awHeldR <= 1'b1;
                awAddrR <= awaddr;
            end else if (doWrite) begin
                awHeldR <= 1'b0;
            end
            if (wvalid && wready) begin
                wHeldR <= 1'b1;
                wByteR <= wdata[7:0]; // byte lane 0 carries every register
                wStrbR <= wstrb;
            end else if (doWrite) begin
                wHeldR <= 1'b0;
            end
        end
    end

    // write response, one cycle after both halves are held
    always @(posedge sys_clk) begin
        if (srst) begin
            bvalid <= 1'b0;
            bresp <= `FTS_RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrResp;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // options register
    // ----------------------------------------------------------------

    // loaded from the option byte while reset is held; no bus path
    // writes it, and reserved bits are shown as programmed
    // the unlock is sticky: once seen it holds until the next reset,
    // whatever the key comparator does afterwards
    always @(posedge sys_clk) begin
        if (srst) begin
            optionsR <= nvOptionsByte;
            unlockedR <= 1'b0;
        end else if (backdoorUnlock) begin
            unlockedR <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // timing divider register
    // ----------------------------------------------------------------

    // a write landing after a lock is dropped; a write with the loaded
    // bit clear locks until reset, one with it set leaves it open
    always @(posedge sys_clk) begin
        if (srst) begin
            divLoadedR <= 1'b0;
            divLockedR <= 1'b0;
            prescaleR <= 1'b0;
            divValueR <= 6'h00;
        end else if (divWrite && !divLockedR) begin
            divLoadedR <= 1'b1;
            divLockedR <= !wByteR[`FTS_DIV_LOADED_BIT];
            prescaleR <= wByteR[`FTS_PRESCALE_BIT];
            divValueR <= wByteR[`FTS_DIV_VALUE_MSB:0];
        end
    end

    // ----------------------------------------------------------------
    // key access configuration register
    // ----------------------------------------------------------------

    // only the access bit is stored; it follows software only while the
    // option byte enables backdoor keys
    always @(posedge sys_clk) begin
        if (srst) begin
            keyAccessR <= 1'b0;
        end else if (wrOk && wrOfs == `FTS_KEY_CFG_OFS && backdoorKeyEnable) begin
            keyAccessR <= wByteR[`FTS_KEY_ACCESS_BIT];
        end
    end

    // ----------------------------------------------------------------
    // timing clock divider
    // ----------------------------------------------------------------

    // at this 250 mhz bus clock even the largest ratio of 512 leaves the
    // timing clock near 490 khz, well above the band the program and erase
    // algorithms need; software is expected to slow the bus clock first,
    // and nothing here refuses a setting outside the band

    // prescaler passes every cycle, or one in eight when selected
    assign preTick = !prescaleR || (preCntR == `FTS_PRESCALE_LAST);

    // ratio is (value + 1) prescaler ticks; held idle until the divider
    // has been written and restarted on every accepted write so that a
    // new ratio never runs a partial old period
    always @(posedge sys_clk) begin
        if (srst || (divWrite && !divLockedR) || !divLoadedR) begin
            preCntR <= 3'h0;
            divCntR <= 6'h00;
            timingTick <= 1'b0;
        end else begin
            preCntR <= preCntR + 3'h1;
            timingTick <= 1'b0;
            if (preTick) begin
                if (divCntR == divValueR) begin
                    divCntR <= 6'h00;
                    timingTick <= 1'b1;
                end else begin
                    divCntR <= divCntR + 6'h01;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // flash array access steering
    // ----------------------------------------------------------------

    // array writes become either a command start or a key, never both
    always @(posedge sys_clk) begin
        if (srst) begin
            commandWriteStart <= 1'b0;
            backdoorKeyWrite <= 1'b0;
        end else begin
            commandWriteStart <= arrayWrite && !keyAccessR;
            backdoorKeyWrite <= arrayWrite && keyAccessR;
        end
    end

    // reads are not gated by key access at all
    assign arrayReadGrant = arrayRead;

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------

    assign arready = !rvalid;

    // register read mux; unlisted words in the window read zero
    always @* begin
        case (wordOfs(araddr))
            `FTS_TIMING_DIV_OFS: begin
                readByte = {divLoadedR, prescaleR, divValueR};
            end
            `FTS_SECURITY_OPTIONS_OFS: begin
                readByte = {optionsR[7:2], securityField};
            end
            `FTS_KEY_CFG_OFS: begin
                readByte = `FTS_BYTE_ZERO;
                readByte[`FTS_KEY_ACCESS_BIT] = keyAccessR;
            end
            default: begin
                readByte = `FTS_BYTE_ZERO;
            end
        endcase
    end

    // read data one cycle after the address is taken, held until rready
    always @(posedge sys_clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata <= `FTS_WORD_ZERO;
            rresp <= `FTS_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= accessResp(araddr, 1'b0, 4'h0);
            if (accessResp(araddr, 1'b0, 4'h0) == `FTS_RESP_OKAY) begin
                rdata <= {24'h000000, readByte};
            end else begin
                rdata <= `FTS_WORD_ZERO;
            end
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

endmodule

// ===== core/flash_timing_and_security_cfg_map.vh
// register map, field positions, codes and reset values of the flash
// timing and security configuration front end; definitions only
`ifndef FLASH_TIMING_AND_SECURITY_CFG_MAP_VH
`define FLASH_TIMING_AND_SECURITY_CFG_MAP_VH

// ----------------------------------------------------------------
// bus geometry
// ----------------------------------------------------------------
`define FTS_ADDR_W 8
`define FTS_REG_COUNT 5'h10
`define FTS_IDX_LSB 2
`define FTS_IDX_MSB 5
`define FTS_TOP_LSB 6
`define FTS_BYTE_STRB 4'h1

// ----------------------------------------------------------------
// register byte offsets, one aligned word each
// ----------------------------------------------------------------
`define FTS_TIMING_DIV_OFS 8'h00
`define FTS_SECURITY_OPTIONS_OFS 8'h04
`define FTS_KEY_CFG_OFS 8'h08

// ----------------------------------------------------------------
// timing_clock_divider fields
// ----------------------------------------------------------------
`define FTS_DIV_LOADED_BIT 7
`define FTS_PRESCALE_BIT 6
`define FTS_DIV_VALUE_MSB 5
`define FTS_PRESCALE_LAST 3'h7

// ----------------------------------------------------------------
// security_options and key_access_config fields
// ----------------------------------------------------------------
`define FTS_KEY_ENABLE_MSB 7
`define FTS_KEY_ENABLE_LSB 6
`define FTS_SECURITY_MSB 1
`define FTS_SECURITY_LSB 0
`define FTS_KEY_ENABLE_ON 2'h2
`define FTS_SECURITY_SECURED 2'h2
`define FTS_SECURITY_FORCED_OPEN 2'h3
`define FTS_KEY_ACCESS_BIT 5

// ----------------------------------------------------------------
// bus responses and reset values
// ----------------------------------------------------------------
`define FTS_RESP_OKAY 2'h0
`define FTS_RESP_SLVERR 2'h2
`define FTS_RESP_DECERR 2'h3
`define FTS_BYTE_ZERO 8'h00
`define FTS_WORD_ZERO 32'h00000000

`endif
